// *** hw/css_bus_if.sv ***
// css_bus_if: the two open-drain wires between master and device
// Assumes pull-ups: a wire is low only while some end drives it low
`timescale 1ns/10ps
`default_nettype none
interface css_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_s_oe & ~sda_s_o);
  modport mst (
    output scl_o, scl_oe, sda_m_o, sda_m_oe,
    input scl, sda
  );
  modport dev (
    output sda_s_o, sda_s_oe,
    input scl, sda
  );
endinterface
`default_nettype wire

// *** hw/css_dev.sv ***
// css_dev: configuration byte slave of the clock synthesizer
// Assumes scl and sda synchronous to ref_clk; bus master drives scl
`timescale 1ns/10ps
`default_nettype none
module css_dev #(
  parameter logic [7:0] ID_BYTE = 8'h5A, // Arbitrary identity value
  parameter int TEST_DIV = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  css_bus_if.dev bus,
  output logic out_pair1_enable,
  output logic out_pair2_enable,
  output logic spread_enable,
  output logic spread_depth_select,
  output logic test_mode,
  output logic test_sel,
  output logic test_clk_out,
  output logic test_clk_oe
);
  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_ADDR = 6'b000010,
    D_CMD = 6'b000100,
    D_CNT = 6'b001000,
    D_WDAT = 6'b010000,
    D_READ = 6'b100000
  } css_dstate_t;

  css_dstate_t state;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic mst_ack;
  logic sel;
  logic blk;
  logic cnt_first;
  logic rd_first;
  logic [4:0] idx;
  logic sda_pull;
  logic sda_zero;
  logic [7:0] cfg [8];
  logic [7:0] next_tx;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic wr_en;
  logic [$clog2(TEST_DIV)-1:0] div_cnt;

  function automatic logic [7:0] rd_byte(input logic [4:0] i);
    if (i >= css_pkg::NUM_CFG) begin
      rd_byte = 8'hFF;
    end else if (i[2:0] == css_pkg::CFG_ID) begin
      rd_byte = ID_BYTE;
    end else begin
      rd_byte = cfg[i[2:0]];
    end
  endfunction

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign rise = bus.scl & ~scl_q;
  assign fall = ~bus.scl & scl_q;
  assign start = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop = scl_q & bus.scl & ~sda_q & bus.sda;

  // FFh when not selected; else count first in a block read, otherwise the indexed byte
  always_comb begin
    if (!sel) begin
      next_tx = 8'hFF;
    end else if (blk && cnt_first) begin
      next_tx = css_pkg::BLOCK_COUNT;
    end else begin
      next_tx = rd_byte(idx);
    end
  end

  assign wr_en = fall && (bit_cnt == css_pkg::ACK_SLOT) && (state == D_WDAT)
    && sel && (idx < css_pkg::NUM_CFG) && (idx[2:0] != css_pkg::CFG_ID);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= D_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'hFF;
      mst_ack <= 1'b0;
      sel <= 1'b0;
      blk <= 1'b0;
      cnt_first <= 1'b0;
      rd_first <= 1'b0;
      idx <= 5'h00;
      sda_pull <= 1'b0;
    end else if (start) begin
      state <= D_ADDR;
      bit_cnt <= 4'h0;
      sda_pull <= 1'b0;
    end else if (stop) begin
      state <= D_IDLE;
      sda_pull <= 1'b0;
    end else if (state != D_IDLE) begin
      if (rise) begin
        if (bit_cnt < css_pkg::ACK_SLOT) begin
          rx_sh <= {rx_sh[6:0], bus.sda};
        end else begin
          mst_ack <= ~bus.sda;
        end
        bit_cnt <= bit_cnt + 4'h1;
      end else if (fall) begin
        if (bit_cnt == css_pkg::ACK_SLOT) begin
          case (state)
            D_ADDR: begin
              if (rx_sh[7:1] == css_pkg::DEV_ADDR_BYTE[7:1]) begin
                sda_pull <= 1'b1;
                rd_first <= 1'b1;
                state <= rx_sh[0] ? D_READ : D_CMD;
              end else begin
                state <= D_IDLE;
              end
            end
            D_CMD: begin
              sda_pull <= 1'b1;
              sel <= (rx_sh[css_pkg::CS_HI:css_pkg::CS_LO] == css_pkg::CS_SELF);
              blk <= ~rx_sh[css_pkg::CMD_BYTE_BIT];
              cnt_first <= ~rx_sh[css_pkg::CMD_BYTE_BIT];
              if (rx_sh[css_pkg::CMD_BYTE_BIT]) begin
                idx <= rx_sh[css_pkg::IDX_HI:0];
                state <= D_WDAT;
              end else begin
                idx <= 5'h00;
                state <= D_CNT;
              end
            end
            D_CNT: begin
              sda_pull <= 1'b1;
              state <= D_WDAT;
            end
            D_WDAT: begin
              sda_pull <= 1'b1;
              if (blk && idx < css_pkg::NUM_CFG) begin
                idx <= idx + 5'h01;
              end
            end
            default: begin
              sda_pull <= 1'b0;
            end
          endcase
        end else if (bit_cnt == css_pkg::ACK_DONE) begin
          bit_cnt <= 4'h0;
          if (state == D_READ && (rd_first || mst_ack)) begin
            tx_sh <= next_tx;
            sda_pull <= ~next_tx[7];
            rd_first <= 1'b0;
            if (blk && cnt_first) begin
              cnt_first <= 1'b0;
            end else if (blk && idx < css_pkg::NUM_CFG) begin
              idx <= idx + 5'h01;
            end
          end else if (state == D_READ) begin
            state <= D_IDLE;
            sda_pull <= 1'b0;
          end else begin
            sda_pull <= 1'b0;
          end
        end else if (state == D_READ && bit_cnt != 4'h0) begin
          sda_pull <= ~tx_sh[6];
          tx_sh <= {tx_sh[6:0], 1'b1};
        end
      end
    end
  end

  // Default bytes at reset; identity byte is read-only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        cfg[i] <= css_pkg::CFG_RST[i];
      end
    end else if (wr_en) begin
      cfg[idx[2:0]] <= rx_sh;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sda_zero <= 1'b0;
    end else begin
      sda_zero <= 1'b0;
    end
  end

  assign bus.sda_s_o = sda_zero;
  assign bus.sda_s_oe = sda_pull;

  assign out_pair1_enable = cfg[css_pkg::CFG_OUT][css_pkg::PAIR1_BIT];
  assign out_pair2_enable = cfg[css_pkg::CFG_OUT][css_pkg::PAIR2_BIT];
  assign spread_enable = cfg[css_pkg::CFG_SPREAD][css_pkg::SPREAD_BIT];
  assign spread_depth_select = cfg[css_pkg::CFG_SPREAD][css_pkg::DEPTH_BIT];
  assign test_mode = cfg[css_pkg::CFG_TEST][css_pkg::TMODE_BIT];
  assign test_sel = cfg[css_pkg::CFG_TEST][css_pkg::TSEL_BIT];

  // Reference divided by TEST_DIV in test clock mode, else released
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= '0;
      test_clk_out <= 1'b0;
      test_clk_oe <= 1'b0;
    end else begin
      test_clk_oe <= test_mode & test_sel;
      if (!(test_mode && test_sel)) begin
        div_cnt <= '0;
        test_clk_out <= 1'b0;
      end else if (div_cnt == $bits(div_cnt)'(TEST_DIV / 2 - 1)) begin
        div_cnt <= '0;
        test_clk_out <= ~test_clk_out;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/css_host.sv ***
// css_host: two-wire bus master taking orders over AXI4-Lite
// Assumes the device never stretches scl; one transfer at a time
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module css_host (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  css_bus_if.mst bus
);
  typedef enum logic [10:0] {
    H_IDLE = 11'b00000000001,
    H_START = 11'b00000000010,
    H_ADW = 11'b00000000100,
    H_CMD = 11'b00000001000,
    H_CNT = 11'b00000010000,
    H_WDAT = 11'b00000100000,
    H_RST = 11'b00001000000,
    H_ADR = 11'b00010000000,
    H_RCNT = 11'b00100000000,
    H_RDAT = 11'b01000000000,
    H_STOP = 11'b10000000000
  } css_hstate_t;

  css_hstate_t st;
  css_pkg::css_op_t op;
  logic busy, done, nerr, tick, aw_got, w_got, wr_fire, go, tx, blk, ack_out;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic [4:0] idx;
  logic [3:0] cnt, bitn, k;
  logic [1:0] ph;
  logic [7:0] sh, rcnt;
  logic [7:0] txb [8];
  logic [7:0] rxb [8];
  logic [5:0] qcnt;
  logic scl_pull, sda_pull, lo;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == css_pkg::REG_CTRL) || (a == css_pkg::REG_STAT)
      || (a == css_pkg::REG_TXD0) || (a == css_pkg::REG_TXD1)
      || (a == css_pkg::REG_RXD0) || (a == css_pkg::REG_RXD1);
  endfunction

  function automatic logic [31:0] rd_reg(input logic [7:0] a);
    case (a)
      css_pkg::REG_CTRL: rd_reg = 32'(cnt) << css_pkg::CNT_LO
        | 32'(idx) << css_pkg::IDX_LO | 32'(op) << css_pkg::OP_LO;
      css_pkg::REG_STAT: rd_reg = 32'(rcnt) << css_pkg::RCNT_LO
        | 32'(nerr) << css_pkg::NACK_BIT | 32'(done) << css_pkg::DONE_BIT
        | 32'(busy) << css_pkg::BUSY_BIT;
      css_pkg::REG_TXD0: rd_reg = {txb[3], txb[2], txb[1], txb[0]};
      css_pkg::REG_TXD1: rd_reg = {txb[7], txb[6], txb[5], txb[4]};
      css_pkg::REG_RXD0: rd_reg = {rxb[3], rxb[2], rxb[1], rxb[0]};
      css_pkg::REG_RXD1: rd_reg = {rxb[7], rxb[6], rxb[5], rxb[4]};
      default: rd_reg = 32'h0000_0000;
    endcase
  endfunction

  assign wr_fire = aw_got & w_got & ~bvalid;
  assign go = wr_fire && aw_a == css_pkg::REG_CTRL && w_s[0] && w_d[css_pkg::GO_BIT] && !busy;
  assign blk = op[1];
  assign tx = (st == H_ADW) || (st == H_CMD) || (st == H_CNT) || (st == H_WDAT)
    || (st == H_ADR);
  assign ack_out = (st == H_RCNT) || (st == H_RDAT && k + 4'h1 < cnt);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
      bvalid <= 1'b0;
      bresp <= css_pkg::AXI_OKAY;
      for (int i = 0; i < 8; i++) begin
        txb[i] <= 8'h00;
      end
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_a <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_d <= wdata;
        w_s <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_a) ? css_pkg::AXI_OKAY : css_pkg::AXI_SLVERR;
        for (int b = 0; b < 4; b++) begin
          if (w_s[b] && aw_a == css_pkg::REG_TXD0) txb[b] <= w_d[8*b +: 8];
          if (w_s[b] && aw_a == css_pkg::REG_TXD1) txb[b+4] <= w_d[8*b +: 8];
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= css_pkg::AXI_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_reg(araddr);
      rresp <= mapped(araddr) ? css_pkg::AXI_OKAY : css_pkg::AXI_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Quarter-period enable keeps scl at or below the bus maximum
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      qcnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= busy && qcnt == 6'(css_pkg::QTR_CYC - 1);
      qcnt <= (!busy || qcnt == 6'(css_pkg::QTR_CYC - 1)) ? 6'h00 : qcnt + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= H_IDLE;
      op <= css_pkg::OP_BYTE_WR;
      busy <= 1'b0;
      done <= 1'b0;
      nerr <= 1'b0;
      idx <= 5'h00;
      cnt <= 4'h0;
      bitn <= 4'h0;
      k <= 4'h0;
      ph <= 2'h0;
      sh <= 8'h00;
      rcnt <= 8'h00;
      scl_pull <= 1'b0;
      sda_pull <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        rxb[i] <= 8'h00;
      end
    end else if (go) begin
      st <= H_START;
      busy <= 1'b1;
      done <= 1'b0;
      nerr <= 1'b0;
      op <= css_pkg::css_op_t'(w_d[css_pkg::OP_LO +: 2]);
      idx <= w_d[css_pkg::IDX_LO +: 5];
      cnt <= w_d[css_pkg::CNT_LO +: 4];
      ph <= 2'h0;
      bitn <= 4'h0;
      k <= 4'h0;
    end else if (tick) begin
      ph <= ph + 2'h1;
      case (st)
        H_START, H_RST: begin
          case (ph)
            2'h0: sda_pull <= 1'b0;
            2'h1: scl_pull <= 1'b0;
            2'h2: sda_pull <= 1'b1;
            default: begin
              scl_pull <= 1'b1;
              st <= (st == H_START) ? H_ADW : H_ADR;
              sh <= css_pkg::DEV_ADDR_BYTE | {7'h00, st == H_RST};
            end
          endcase
        end
        H_STOP: begin
          case (ph)
            2'h0: sda_pull <= 1'b1;
            2'h1: scl_pull <= 1'b0;
            2'h2: sda_pull <= 1'b0;
            default: begin
              st <= H_IDLE;
              busy <= 1'b0;
              done <= 1'b1;
            end
          endcase
        end
        H_IDLE: begin
          ph <= 2'h0;
        end
        default: begin
          case (ph)
            2'h0: sda_pull <= (bitn < css_pkg::ACK_SLOT) ? (tx & ~sh[7]) : (~tx & ack_out);
            2'h1: scl_pull <= 1'b0;
            2'h2: begin
              if (bitn < css_pkg::ACK_SLOT) sh <= {sh[6:0], bus.sda};
              else if (tx && bus.sda) nerr <= 1'b1;
            end
            default: begin
              scl_pull <= 1'b1;
              bitn <= (bitn == css_pkg::ACK_SLOT) ? 4'h0 : bitn + 4'h1;
              if (bitn == css_pkg::ACK_SLOT) begin
                if (tx && nerr) begin
                  st <= H_STOP;
                end else begin
                  case (st)
                    H_ADW: begin
                      st <= H_CMD;
                      sh <= blk ? 8'h00 : {1'b1, css_pkg::CS_SELF, idx};
                    end
                    H_CMD: begin
                      if (op[0]) st <= H_RST;
                      else st <= blk ? H_CNT : H_WDAT;
                      sh <= blk ? {4'h0, cnt} : txb[0];
                    end
                    H_CNT: begin
                      st <= H_WDAT;
                      sh <= txb[0];
                    end
                    H_WDAT: begin
                      if (blk && k + 4'h1 < cnt) begin
                        k <= k + 4'h1;
                        sh <= txb[3'(k + 4'h1)];
                      end else begin
                        st <= H_STOP;
                      end
                    end
                    H_ADR: st <= blk ? H_RCNT : H_RDAT;
                    H_RCNT: begin
                      rcnt <= sh;
                      st <= H_RDAT;
                    end
                    H_RDAT: begin
                      rxb[3'(k)] <= sh;
                      if (blk && k + 4'h1 < cnt) k <= k + 4'h1;
                      else st <= H_STOP;
                    end
                    default: st <= H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) lo <= 1'b0;
    else lo <= 1'b0;
  end

  assign bus.scl_o = lo;
  assign bus.sda_m_o = lo;
  assign bus.scl_oe = scl_pull;
  assign bus.sda_m_oe = sda_pull;
endmodule
`default_nettype wire

// *** hw/css_pkg.sv ***
// css_pkg: constants shared by both ends of the serial configuration link
// Assumes a 50 MHz ref_clk at both ends; nothing else
// What this block does
// - Slave answers only address bytes D2h and D3h
// - Command bit 7: zero block, one byte
// - Command bits 6:5 zero select device
// - Command bits 4:0 index; zero for block
// - Byte transfers use command code index
// - Block bytes ascend from zero, MSB first
// - Configuration bytes take defaults at reset
// - Block write: address, command, count, data
// - Block read: command, repeated start, read address
// - Block read returns count, then data
// - Master acks all but last read byte
// - Byte write: address, command, data, stop
// - Byte read: command, restart, one byte, nack
// - Works at serial clock up to 400kHz
// - Each output pair enabled separately
// - Spread on/off and two depths
// - Byte 0 bits 4,3 enable pairs
// - Byte 2 bit 7 selects spread depth
// - Byte 2 bit 2 enables spread
// - Byte 6 bits 6,7 test clock mode
package css_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SCL_MAX_HZ = 400_000;
  localparam int QTR_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam logic [7:0] DEV_ADDR_BYTE = 8'hD2;
  localparam int CMD_BYTE_BIT = 7;
  localparam int CS_HI = 6;
  localparam int CS_LO = 5;
  localparam int IDX_HI = 4;
  localparam logic [1:0] CS_SELF = 2'h0;
  localparam logic [4:0] NUM_CFG = 5'h08;
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  localparam logic [7:0] CFG_RST [8] = '{
    8'h7C, 8'h00, 8'hEA, 8'hAF, 8'h01, 8'h00, 8'h13, 8'h00};
  localparam logic [2:0] CFG_OUT = 3'h0;
  localparam logic [2:0] CFG_SPREAD = 3'h2;
  localparam logic [2:0] CFG_TEST = 3'h6;
  localparam logic [2:0] CFG_ID = 3'h7;
  localparam int PAIR2_BIT = 4;
  localparam int PAIR1_BIT = 3;
  localparam int DEPTH_BIT = 7;
  localparam int SPREAD_BIT = 2;
  localparam int TSEL_BIT = 7;
  localparam int TMODE_BIT = 6;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TXD0 = 8'h08;
  localparam logic [7:0] REG_TXD1 = 8'h0C;
  localparam logic [7:0] REG_RXD0 = 8'h10;
  localparam logic [7:0] REG_RXD1 = 8'h14;
  localparam int GO_BIT = 0;
  localparam int OP_LO = 1;
  localparam int IDX_LO = 4;
  localparam int CNT_LO = 12;
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int NACK_BIT = 2;
  localparam int RCNT_LO = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    OP_BYTE_WR = 2'h0,
    OP_BYTE_RD = 2'h1,
    OP_BLK_WR = 2'h2,
    OP_BLK_RD = 2'h3
  } css_op_t;
endpackage

// *** tb/css_link_asserts.sv ***
// css_link_asserts: timing and role checks on the two-wire link
// Assumes it watches the one interface that joins css_host and css_dev
`timescale 1ns/10ps
`default_nettype none
module css_link_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int MIN_PER = 125;
  logic scl_q;
  int unsigned per_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Cycles since the last scl rise, saturating
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      per_cnt <= 1000;
    end else begin
      scl_q <= scl;
      if (scl && !scl_q) begin
        per_cnt <= 1;
      end else if (per_cnt < 1000) begin
        per_cnt <= per_cnt + 1;
      end
    end
  end
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  AST_SCL_HIGH_HOLD: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  AST_SCL_LOW_HOLD: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  AST_SCL_PERIOD: assert property ((scl && !scl_q) |-> per_cnt >= MIN_PER)
    else $error("scl faster than bus limit");
  AST_START_DEV_QUIET: assert property (s_start |-> !sda_s_oe)
    else $error("device holds sda at start");
  AST_START_CLOCK: assert property (s_start |-> ##[1:200] !scl)
    else $error("no clock after start");
  AST_STOP_IDLE: assert property (s_stop |->
    (scl && sda && !scl_oe && !sda_m_oe && !sda_s_oe) [*8])
    else $error("link not idle after stop");
  AST_DEV_LOW_CHANGE: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device changed sda while scl high");
  AST_ONE_OWNER: assert property (scl |-> !(sda_s_oe && sda_m_oe))
    else $error("both ends drive sda");
  AST_SDA_STABLE: assert property ((scl && $past(scl) && $changed(sda)) |->
    ($changed(sda_m_oe) && !sda_s_oe))
    else $error("sda changed during scl high");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: host and device joined over the link, driven through AXI4-Lite
// Assumes the host runs each order to its stop before it reports done
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] ID_VAL = 8'hA5; // Arbitrary identity value
  logic ref_clk, resetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, pair1_en, pair2_en, spr_en, spr_deep, tmode, tsel, tclk_oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] exp [8];
  logic [63:0] wv;
  logic tclk, tc;
  int fail_count, num_checks, nb;
  css_bus_if bus_inst ();
  css_host css_host_inst (.ref_clk(ref_clk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bus(bus_inst));
  css_dev #(.ID_BYTE(ID_VAL), .TEST_DIV(4)) css_dev_inst (.ref_clk(ref_clk),
    .resetn(resetn), .bus(bus_inst), .out_pair1_enable(pair1_en), .out_pair2_enable(pair2_en),
    .spread_enable(spr_en), .spread_depth_select(spr_deep), .test_mode(tmode),
    .test_sel(tsel), .test_clk_out(tclk), .test_clk_oe(tclk_oe));
  css_link_asserts css_link_asserts_inst (.ref_clk(ref_clk), .resetn(resetn),
    .scl_oe(bus_inst.scl_oe), .sda_m_oe(bus_inst.sda_m_oe), .sda_s_oe(bus_inst.sda_s_oe),
    .scl(bus_inst.scl), .sda(bus_inst.sda));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] word_of(input int w);
    return {exp[4*w+3], exp[4*w+2], exp[4*w+1], exp[4*w]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task timeout;
    fail_count++;
    $display("ERROR %0t: wait ran out", $time);
    end_sim();
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 1000);
    bready <= 1'b0;
    r = bresp;
    if (n >= 1000) timeout();
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 1000);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 1000) timeout();
  endtask
  task run(input logic [1:0] op, input logic [4:0] idx, input logic [3:0] cnt);
    int n;
    n = 0;
    axi_wr(css_pkg::REG_CTRL, {16'h0, cnt, 3'h0, idx, 1'b0, op, 1'b1}, rs);
    do begin
      repeat (50) @(posedge ref_clk);
      axi_rd(css_pkg::REG_STAT, rd, rs);
      n++;
    end while (!(rd[css_pkg::DONE_BIT] && !rd[css_pkg::BUSY_BIT]) && n < 600);
    if (n >= 600) timeout();
    check(rd[css_pkg::NACK_BIT], 0);
  endtask
  task check_outs;
    check(pair1_en, exp[0][css_pkg::PAIR1_BIT]);
    check(pair2_en, exp[0][css_pkg::PAIR2_BIT]);
    check(spr_en, exp[2][css_pkg::SPREAD_BIT]);
    check(spr_deep, exp[2][css_pkg::DEPTH_BIT]);
    check(tmode, exp[6][css_pkg::TMODE_BIT]);
    check(tsel, exp[6][css_pkg::TSEL_BIT]);
    check(tclk_oe, exp[6][css_pkg::TMODE_BIT] & exp[6][css_pkg::TSEL_BIT]);
  endtask
  task byte_wr(input logic [4:0] i, input logic [7:0] v);
    axi_wr(css_pkg::REG_TXD0, {24'h0, v}, rs);
    check(rs, css_pkg::AXI_OKAY);
    run(css_pkg::OP_BYTE_WR, i, 4'h1);
    exp[i[2:0]] = v;
    check_outs();
  endtask
  task blk_rd;
    run(css_pkg::OP_BLK_RD, 5'h00, 4'h8);
    check(rd[15:8], css_pkg::BLOCK_COUNT);
    axi_rd(css_pkg::REG_RXD0, rd, rs);
    check(rd, word_of(0));
    axi_rd(css_pkg::REG_RXD1, rd, rs);
    check(rd, word_of(1));
  endtask
  initial begin
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    for (int i = 0; i < 7; i++) exp[i] = css_pkg::CFG_RST[i];
    exp[7] = ID_VAL;
    rd = $urandom(21435);
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    check_outs();
    blk_rd();
    axi_wr(8'h40, 32'h1, rs);
    check(rs, css_pkg::AXI_SLVERR);
    axi_rd(8'h40, rd, rs);
    check(rd, 32'h0);
    byte_wr(5'h00, 8'h08);
    byte_wr(5'h02, 8'($urandom));
    byte_wr(5'h06, 8'h40);
    byte_wr(5'h06, 8'hC0);
    // Divided test clock must toggle once every two reference cycles
    @(posedge ref_clk);
    tc = tclk;
    repeat (2) @(posedge ref_clk);
    check(tclk, !tc);
    run(css_pkg::OP_BYTE_RD, 5'h02, 4'h1);
    axi_rd(css_pkg::REG_RXD0, rd, rs);
    check(rd[7:0], exp[2]);
    run(css_pkg::OP_BYTE_RD, 5'h07, 4'h1);
    axi_rd(css_pkg::REG_RXD0, rd, rs);
    check(rd[7:0], ID_VAL);
    wv = {$urandom, $urandom};
    nb = 1 + $urandom % 8;
    axi_wr(css_pkg::REG_TXD0, wv[31:0], rs);
    axi_wr(css_pkg::REG_TXD1, wv[63:32], rs);
    run(css_pkg::OP_BLK_WR, 5'h00, 4'(nb));
    for (int i = 0; i < nb && i < 7; i++) exp[i] = wv[8*i +: 8];
    check_outs();
    blk_rd();
    end_sim();
  end
endmodule
`default_nettype wire
